//--- dv/tb_wakeup_interrupt_unit.sv
`timescale 1ns/1ns
module tb_wakeup_interrupt_unit;
	import wiu_pkg::*;
	// ------
	// Signals
	// ------
	localparam int SVC_SIM = 20;
	logic clk = 1'b0, nrst = 1'b0, regWr = 1'b0, regRd = 1'b0, monitoredClk = 1'b0, clkRun = 1'b1;
	logic fetchStrobe = 1'b0, execStrobe = 1'b0, intAck = 1'b0;
	logic intReq, coreStopped, coreIdle, wakeEvent, irq;
	logic [7:0] regAddr = 8'h00, regWdata = 8'h00, romData = 8'h00, execOpcode = 8'h00;
	logic [7:0] regRdata, fetchData, wakePin;
	logic [1:0] mcDiv = 2'b00;
	logic [11:0] extIrq = 12'h000;
	logic [15:0] fetchAddr = 16'h0000;
	logic [15:0] intVector;
	int badCount = 0;
	int cmpCount = 0;

	// Core clock, and a slower watched clock that can be stopped
	always #4 clk = ~clk;
	always @(posedge clk) begin
		mcDiv <= mcDiv + 2'b01;
		if (clkRun && mcDiv == 2'b11) begin
			monitoredClk <= ~monitoredClk;
		end
	end

	wiu_pin_source u_pins (.clk(clk), .pins(wakePin));
	wiu_top #(.SERVICE_LIMIT(SVC_SIM), .CLKMON_LIMIT(30), .ROM_WORDS(4096)) u_dut (
		.clk(clk), .nrst(nrst), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
		.regRdata(regRdata), .wakePin(wakePin), .monitoredClk(monitoredClk), .extIrq(extIrq),
		.fetchStrobe(fetchStrobe), .fetchAddr(fetchAddr), .romData(romData), .fetchData(fetchData),
		.execStrobe(execStrobe), .execOpcode(execOpcode), .intAck(intAck), .intReq(intReq),
		.intVector(intVector), .coreStopped(coreStopped), .coreIdle(coreIdle), .wakeEvent(wakeEvent), .irq(irq)
	);

	// ------
	// Shared tasks
	// ------
	task automatic finalReport();
		if (badCount == 0 && cmpCount > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	task automatic check(input logic [15:0] got, input logic [15:0] exp, input string m);
		cmpCount++;
		if (got !== exp) begin
			badCount++;
			$display("MISMATCH %0t %s", $time, m);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		regWr <= 1'b1;
		regAddr <= a;
		regWdata <= d;
		@(posedge clk);
		regWr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e, input string m);
		@(posedge clk);
		regRd <= 1'b1;
		regAddr <= a;
		@(posedge clk);
		regRd <= 1'b0;
		#1;
		check(regRdata, e, m);
	endtask
	// Bounded wait; running out ends the run as a failure
	task automatic waitHigh(ref logic s, input int lim, output int n);
		n = 0;
		do begin
			@(posedge clk);
			#1;
			n++;
		end while (s !== 1'b1 && n < lim);
		if (s !== 1'b1) begin
			badCount++;
			finalReport();
		end
	endtask
	task automatic settle(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	// ------
	// Scenarios
	// ------
	task automatic regsTest();
		rd(OFS_WAKE_EDGE_SELECT, RST_BYTE, "edge reset");
		rd(OFS_WAKE_ENABLE_MASK, RST_BYTE, "enable reset");
		rd(OFS_WAKE_PENDING_FLAGS, RST_BYTE, "pending reset");
		wr(OFS_WAKE_EDGE_SELECT, 8'hA5);
		rd(OFS_WAKE_EDGE_SELECT, 8'hA5, "edge readback");
		wr(8'h0C, 8'hFF);
		rd(8'h0C, 8'h00, "unmapped read");
	endtask
	task automatic wakeTest();
		wr(OFS_WAKE_EDGE_SELECT, 8'h0F);
		wr(OFS_WAKE_ENABLE_MASK, 8'h7F);
		wr(OFS_EVENT_MASK, 8'h01);
		wr(OFS_VECTOR_BASE, 8'h12);
		rd(OFS_VECTOR_BASE, 8'h12, "vector base readback");
		wr(OFS_SRC_ENABLE_LO, 8'h01);
		wr(OFS_CONTROL, 8'h01);
		u_pins.drive(8'hFF, 0);
		settle(6);
		rd(OFS_WAKE_PENDING_FLAGS, 8'h0F, "rising edges");
		check(intReq, 1'b1, "wake request");
		check(intVector, {8'h12, 3'b000, SRC_WAKE, 1'b0}, "wake vector");
		check(irq, 1'b1, "wake irq");
		u_pins.drive(8'h00, 2);
		settle(6);
		rd(OFS_WAKE_PENDING_FLAGS, 8'h7F, "falling edges");
		wr(OFS_EVENT_STATUS, 8'h01);
		settle(2);
		check(irq, 1'b0, "irq cleared");
		rd(OFS_WAKE_PENDING_FLAGS, 8'h7F, "pending sticky");
		wr(OFS_WAKE_PENDING_FLAGS, 8'hFF);
		settle(2);
		check(intReq, 1'b0, "request dropped");
	endtask
	task automatic powerTest();
		int n;
		wr(OFS_WAKE_EDGE_SELECT, 8'hFF);
		wr(OFS_WAKE_ENABLE_MASK, 8'h01);
		wr(OFS_LOW_POWER, 8'h01);
		u_pins.drive(8'h02, 0);
		settle(6);
		check(coreStopped, 1'b1, "disabled pin woke");
		u_pins.drive(8'h03, 0);
		waitHigh(wakeEvent, 10, n);
		settle(1);
		check(coreStopped, 1'b0, "stop exit");
		u_pins.drive(8'h00, 0);
		wr(OFS_LOW_POWER, 8'h02);
		settle(0);
		check(coreIdle, 1'b1, "idle entry");
		u_pins.drive(8'h01, 3);
		waitHigh(wakeEvent, 12, n);
		settle(1);
		check(coreIdle, 1'b0, "idle exit");
		wr(OFS_WAKE_PENDING_FLAGS, 8'hFF);
	endtask
	task automatic timerTest();
		int n;
		wr(OFS_EVENT_STATUS, 8'hFF);
		wr(OFS_EVENT_MASK, 8'h02);
		wr(OFS_CONTROL, 8'h02);
		waitHigh(irq, 2100, n);
		wr(OFS_EVENT_STATUS, 8'h02);
		waitHigh(irq, 2100, n);
		check(n + 2, 1 << IDLE_TICK_BIT, "tick interval");
		wr(OFS_CONTROL, 8'h00);
		wr(OFS_EVENT_STATUS, 8'hFF);
	endtask
	task automatic vectorTest();
		wr(OFS_CONTROL, 8'h01);
		wr(OFS_SRC_ENABLE_LO, 8'hFF);
		wr(OFS_SRC_ENABLE_HI, 8'h3F);
		rd(OFS_SRC_ENABLE_HI, 8'h3F, "enable hi readback");
		for (int k = 0; k < NUM_EXT_IRQ; k++) begin
			@(posedge clk);
			extIrq <= 12'h001 << k;
			settle(3);
			check(intVector, {8'h12, 3'b000, 4'(k + 2), 1'b0}, "source vector");
		end
		@(posedge clk);
		extIrq <= 12'hFFF;
		wr(OFS_SRC_ENABLE_HI, 8'h00);
		settle(2);
		check(intVector, {8'h12, 3'b000, 4'h7, 1'b0}, "masked sources");
		wr(OFS_CONTROL, 8'h00);
		settle(2);
		check(intReq, 1'b0, "global off");
		@(posedge clk);
		extIrq <= 12'h000;
	endtask
	task automatic trapTest();
		int n;
		@(posedge clk);
		fetchStrobe <= 1'b1;
		fetchAddr <= 16'h0010;
		romData <= 8'h5A;
		@(posedge clk);
		fetchAddr <= 16'h1000;
		settle(0);
		check(fetchData, 8'h5A, "rom fetch");
		@(posedge clk);
		fetchStrobe <= 1'b0;
		execStrobe <= 1'b1;
		execOpcode <= ILLEGAL_OPCODE;
		settle(0);
		check(fetchData, 8'h00, "undefined fetch");
		@(posedge clk);
		execStrobe <= 1'b0;
		waitHigh(intReq, 4, n);
		check(intVector[4:1], SRC_ILLEGAL, "trap source");
		@(posedge clk);
		intAck <= 1'b1;
		@(posedge clk);
		intAck <= 1'b0;
		settle(3);
		check(intReq, 1'b0, "trap acknowledged");
		wr(OFS_EVENT_STATUS, 8'hFF);
	endtask
	task automatic monitorTest();
		int n;
		wr(OFS_SERVICE, 8'h00);
		wr(OFS_CONTROL, 8'h04);
		repeat (6) begin
			settle(8);
			wr(OFS_SERVICE, 8'h00);
		end
		check(intReq, 1'b0, "serviced in time");
		waitHigh(intReq, SVC_SIM + 10, n);
		check(intVector[4:1], SRC_MONITOR, "runaway source");
		rd(OFS_EVENT_STATUS, 8'h04, "runaway status");
		wr(OFS_CONTROL, 8'h08);
		wr(OFS_EVENT_STATUS, 8'hFF);
		settle(40);
		check(intReq, 1'b0, "clock running");
		clkRun <= 1'b0;
		waitHigh(intReq, 60, n);
		rd(OFS_EVENT_STATUS, 8'h08, "clock loss status");
		clkRun <= 1'b1;
		wr(OFS_CONTROL, 8'h00);
	endtask

	// ------
	// Main sequence and hang guard
	// ------
	initial begin
		repeat (10) @(posedge clk);
		nrst <= 1'b1;
		@(posedge clk);
		regsTest();
		wakeTest();
		powerTest();
		timerTest();
		vectorTest();
		trapTest();
		monitorTest();
		finalReport();
	end
	initial begin
		repeat (100000) @(posedge clk);
		badCount++;
		finalReport();
	end
endmodule

//--- dv/wiu_checker.sv
`timescale 1ns/1ns
// ------
// Port checker
// ------
module wiu_checker
	import wiu_pkg::*;
#(
	parameter int SERVICE_LIMIT = 20,
	parameter int CLKMON_LIMIT = 30,
	parameter int ROM_WORDS = 4096
)(
	// Clock and reset
	input wire logic clk,
	input wire logic nrst,
	// Register port
	input wire logic [wiu_pkg::ADDR_W-1:0] regAddr,
	input wire logic [wiu_pkg::DATA_W-1:0] regWdata,
	input wire logic regWr,
	input wire logic regRd,
	input wire logic [wiu_pkg::DATA_W-1:0] regRdata,
	// Pins and requests
	input wire logic [7:0] wakePin,
	input wire logic monitoredClk,
	input wire logic [wiu_pkg::NUM_EXT_IRQ-1:0] extIrq,
	// Core side
	input wire logic fetchStrobe,
	input wire logic [15:0] fetchAddr,
	input wire logic [7:0] romData,
	input wire logic [7:0] fetchData,
	input wire logic execStrobe,
	input wire logic [7:0] execOpcode,
	input wire logic intAck,
	input wire logic intReq,
	input wire logic [15:0] intVector,
	input wire logic coreStopped,
	input wire logic coreIdle,
	input wire logic wakeEvent,
	input wire logic irq
);
	// One domain, so clock and reset are given once
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);

	// Read data only in the cycle after a read strobe
	a_rdata_quiet: assert property (!$past(regRd) |-> regRdata == 8'h00) else $error("stray read data");
	// Fetches inside and outside the program store
	a_fetch_rom: assert property (fetchStrobe && fetchAddr < ROM_WORDS |=> fetchData == $past(romData))
		else $error("fetch data wrong");
	a_fetch_zero: assert property (fetchStrobe && fetchAddr >= ROM_WORDS |=> fetchData == 8'h00)
		else $error("undefined fetch not zero");
	a_fetch_hold: assert property (!fetchStrobe |=> $stable(fetchData)) else $error("fetch data moved");
	// The trap cannot be masked, whatever the enables
	a_trap_vector: assert property (execStrobe && execOpcode == ILLEGAL_OPCODE |->
		##[1:3] intReq && intVector[4:1] == SRC_ILLEGAL) else $error("no trap request");
	// Two-byte entries of a 32-byte table
	a_vector_slot: assert property (intReq |-> intVector[7:5] == 3'b000 && !intVector[0])
		else $error("vector off table");
	// Low-power entry and wake pulse
	a_stop_entry: assert property (regWr && regAddr == OFS_LOW_POWER && regWdata[LP_STOP] |=> coreStopped)
		else $error("stop not entered");
	a_idle_entry: assert property (regWr && regAddr == OFS_LOW_POWER && regWdata[1:0] == 2'b10 |=> coreIdle)
		else $error("idle not entered");
	a_wake_pulse: assert property (wakeEvent |=> !wakeEvent) else $error("wake pulse too long");
	a_wake_run: assert property (wakeEvent |-> ##[0:1] !coreStopped && !coreIdle) else $error("still asleep");
endmodule

bind wiu_top wiu_checker #(
	.SERVICE_LIMIT(SERVICE_LIMIT), .CLKMON_LIMIT(CLKMON_LIMIT), .ROM_WORDS(ROM_WORDS)
) u_chk (
	.clk(clk), .nrst(nrst), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
	.regRdata(regRdata), .wakePin(wakePin), .monitoredClk(monitoredClk), .extIrq(extIrq),
	.fetchStrobe(fetchStrobe), .fetchAddr(fetchAddr), .romData(romData), .fetchData(fetchData),
	.execStrobe(execStrobe), .execOpcode(execOpcode), .intAck(intAck), .intReq(intReq),
	.intVector(intVector), .coreStopped(coreStopped), .coreIdle(coreIdle), .wakeEvent(wakeEvent), .irq(irq)
);

//--- dv/wiu_pin_source.sv
`timescale 1ns/1ns
// ------
// Wake pin sources
// ------
module wiu_pin_source (
	// Clock
	input wire logic clk,
	// Pin levels
	output logic [7:0] pins
);
	// Pins idle low, so the first level seen after reset makes no edge
	initial pins = 8'h00;

	// Move the pins after a lag, so one source can act promptly or slowly
	task automatic drive(input logic [7:0] lvl, input int lag);
		repeat (lag) @(posedge clk);
		@(posedge clk);
		pins <= lvl;
	endtask
endmodule

//--- include/wiu_pkg.sv
// ----------------------------------------------------------------
// Wakeup and interrupt unit constants
// ----------------------------------------------------------------
package wiu_pkg;

	// ------------------------------------------------------------
	// Register bus geometry
	// ------------------------------------------------------------
	localparam int ADDR_W = 8;
	localparam int DATA_W = 8;

	// ------------------------------------------------------------
	// Register offsets
	// ------------------------------------------------------------
	localparam logic [7:0] OFS_WAKE_EDGE_SELECT = 8'h00;
	localparam logic [7:0] OFS_WAKE_ENABLE_MASK = 8'h01;
	localparam logic [7:0] OFS_WAKE_PENDING_FLAGS = 8'h02;
	localparam logic [7:0] OFS_EVENT_STATUS = 8'h03;
	localparam logic [7:0] OFS_EVENT_MASK = 8'h04;
	localparam logic [7:0] OFS_CONTROL = 8'h05;
	localparam logic [7:0] OFS_VECTOR_BASE = 8'h06;
	localparam logic [7:0] OFS_SERVICE = 8'h07;
	localparam logic [7:0] OFS_SRC_ENABLE_LO = 8'h08;
	localparam logic [7:0] OFS_SRC_ENABLE_HI = 8'h09;
	localparam logic [7:0] OFS_LOW_POWER = 8'h0A;

	// ------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [15:0] RST_WORD = 16'h0000;

	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	// Event status and mask
	localparam int EV_WAKE = 0;
	localparam int EV_TIMER = 1;
	localparam int EV_RUNAWAY = 2;
	localparam int EV_CLKLOSS = 3;
	localparam int EV_ILLEGAL = 4;
	localparam int EV_W = 5;
	// Control register
	localparam int CTL_GIE = 0;
	localparam int CTL_TIMER_IE = 1;
	localparam int CTL_SVC_EN = 2;
	localparam int CTL_CLKMON_EN = 3;
	// Low power request register
	localparam int LP_STOP = 0;
	localparam int LP_IDLE = 1;

	// ------------------------------------------------------------
	// Interrupt sources
	// ------------------------------------------------------------
	localparam int NUM_SRC = 16;
	localparam int NUM_MASKABLE = 14;
	localparam int NUM_EXT_IRQ = 12;
	localparam logic [3:0] SRC_WAKE = 4'h0;
	localparam logic [3:0] SRC_TIMER = 4'h1;
	localparam logic [3:0] SRC_MONITOR = 4'hE;
	localparam logic [3:0] SRC_ILLEGAL = 4'hF;
	localparam logic [7:0] ILLEGAL_OPCODE = 8'h00;

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int CLK_MHZ = 125;
	localparam int IDLE_TIMER_W = 16;
	localparam int IDLE_TICK_BIT = 11;
	localparam int IDLE_PERIOD_MS = 4;
	localparam int IDLE_RATE_MHZ = 1;
	localparam int IDLE_PERIOD_CYC = IDLE_PERIOD_MS * 1000 * IDLE_RATE_MHZ;
	localparam int SVC_LIMIT_US = 1000;
	localparam int SVC_LIMIT_CYC = SVC_LIMIT_US * CLK_MHZ;
	localparam int CLKMON_MIN_KHZ = 10;
	localparam int CLKMON_LIMIT_CYC = (CLK_MHZ * 1000) / CLKMON_MIN_KHZ;
	localparam int SYNC_STAGES = 3;

endpackage

//--- verilog/wiu_top.sv
// Implementation choices: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ns
// Functional notes
// - An enabled wake pin transition brings the core out of both the stopped and the idle state.
// - The eight wake pins share one edge-selectable interrupt source, source 0, raised by any enabled pending bit.
// - Three 8-bit registers steer the wake logic, bit n of each belonging to pin n.
// - A pin whose enable bit is clear takes no part in wakeup or interrupts.
// - Each edge-select bit chooses a rising or a falling edge as the pin's trigger.
// - The selected edge on a pin is latched into that pin's pending bit.
// - Sixteen vectored sources exist, fourteen maskable and two that cannot be masked.
// - Each source fetches a two-byte vector out of a 32-byte table whose place software chooses.
// - A fetch from an undefined program location returns zeroes and executing it raises a non-maskable trap.
// - A 16-bit idle timer counts every instruction cycle and never stops.
// - The idle timer has no address and cannot be read or written.
// - Each toggle of the twelfth timer bit may raise an interrupt when software enables it.
// - A service monitor counts cycles between software services and flags a runaway program.
// - A clock monitor reports a missing or too slow monitored clock.
module wiu_top
	import wiu_pkg::*;
#(
	parameter int SERVICE_LIMIT = wiu_pkg::SVC_LIMIT_CYC,
	parameter int CLKMON_LIMIT = wiu_pkg::CLKMON_LIMIT_CYC,
	parameter int ROM_WORDS = 4096
)(
	// Clock and reset
	input wire logic clk,
	input wire logic nrst,
	// Register port
	input wire logic [wiu_pkg::ADDR_W-1:0] regAddr,
	input wire logic [wiu_pkg::DATA_W-1:0] regWdata,
	input wire logic regWr,
	input wire logic regRd,
	output logic [wiu_pkg::DATA_W-1:0] regRdata,
	// Wake capable pins and monitored clock
	input wire logic [7:0] wakePin,
	input wire logic monitoredClk,
	// Peripheral interrupt requests
	input wire logic [wiu_pkg::NUM_EXT_IRQ-1:0] extIrq,
	// Core program fetch and execute
	input wire logic fetchStrobe,
	input wire logic [15:0] fetchAddr,
	input wire logic [7:0] romData,
	output logic [7:0] fetchData,
	input wire logic execStrobe,
	input wire logic [7:0] execOpcode,
	input wire logic intAck,
	// Core interrupt and power control
	output logic intReq,
	output logic [15:0] intVector,
	output logic coreStopped,
	output logic coreIdle,
	output logic wakeEvent,
	output logic irq
);
	import wiu_pkg::*;

	typedef enum {WIU_RUN, WIU_STOP, WIU_IDLE} wiu_power_e;

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	// Trigger test per pin: rising when select is one, falling otherwise
	function automatic logic [7:0] wiuEdgeHit(input logic [7:0] prev, input logic [7:0] cur,
		input logic [7:0] sel);
		wiuEdgeHit = (sel & ~prev & cur) | (~sel & prev & ~cur);
	endfunction

	// Write strobe decode for one offset
	function automatic logic wiuWrHit(input logic wr, input logic [7:0] addr, input logic [7:0] ofs);
		wiuWrHit = wr && (addr == ofs);
	endfunction

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	logic [7:0] wakeEdgeSelect;
	logic [7:0] wakeEnableMask;
	logic [7:0] wakePendingFlags;
	logic [EV_W-1:0] eventStatus;
	logic [EV_W-1:0] eventMask;
	logic [7:0] control;
	logic [7:0] vectorBase;
	logic [NUM_MASKABLE-1:0] srcEnable;
	logic [7:0] pinS1;
	logic [7:0] pinS2;
	logic [7:0] pinS3;
	logic [7:0] pinLevel;
	logic [7:0] pinEdge;
	logic [IDLE_TIMER_W-1:0] idleCount;
	logic timerTick;
	logic [31:0] svcCount;
	logic runawayHit;
	logic [2:0] mclkSync;
	logic mclkPrev;
	logic [31:0] mclkGap;
	logic clkLossHit;
	logic illegalTrap;
	logic illegalHit;
	logic wakeAny;
	logic [NUM_SRC-1:0] srcReq;
	logic [3:0] srcIdx;
	logic srcValid;
	wiu_power_e power;
	wiu_power_e next_power;

	// ------------------------------------------------------------
	// Pin synchroniser
	// ------------------------------------------------------------
	// Three stages; a level is accepted only once stages two and three agree
	always_ff @(posedge clk) begin
		if (!nrst) begin
			pinS1 <= RST_BYTE;
			pinS2 <= RST_BYTE;
			pinS3 <= RST_BYTE;
		end else begin
			pinS1 <= wakePin;
			pinS2 <= pinS1;
			pinS3 <= pinS2;
		end
	end

	// Filtered level; it resets low, so a high first level after reset makes a rising edge
	always_ff @(posedge clk) begin
		if (!nrst) begin
			pinLevel <= RST_BYTE;
		end else begin
			pinLevel <= (pinS2 & pinS3) | (pinLevel & (pinS2 ^ pinS3));
		end
	end

	assign pinEdge = wiuEdgeHit(pinLevel, (pinS2 & pinS3) | (pinLevel & (pinS2 ^ pinS3)),
		wakeEdgeSelect);

	// ------------------------------------------------------------
	// Wake registers
	// ------------------------------------------------------------
	// Edge select and enable mask, one bit per pin
	always_ff @(posedge clk) begin
		if (!nrst) begin
			wakeEdgeSelect <= RST_BYTE;
			wakeEnableMask <= RST_BYTE;
		end else begin
			if (wiuWrHit(regWr, regAddr, OFS_WAKE_EDGE_SELECT)) begin
				wakeEdgeSelect <= regWdata;
			end
			if (wiuWrHit(regWr, regAddr, OFS_WAKE_ENABLE_MASK)) begin
				wakeEnableMask <= regWdata;
			end
		end
	end

	// Pending bits; an edge in the clearing cycle still sets the bit
	generate
		for (genvar i = 0; i < 8; i++) begin : g_pend
			always_ff @(posedge clk) begin
				if (!nrst) begin
					wakePendingFlags[i] <= 1'b0;
				end else if (pinEdge[i] && wakeEnableMask[i]) begin
					wakePendingFlags[i] <= 1'b1;
				end else if (wiuWrHit(regWr, regAddr, OFS_WAKE_PENDING_FLAGS) && regWdata[i]) begin
					wakePendingFlags[i] <= 1'b0;
				end
			end
		end
	endgenerate

	assign wakeAny = |(wakePendingFlags & wakeEnableMask);

	// ------------------------------------------------------------
	// Idle interval timer
	// ------------------------------------------------------------
	// Free running, no address decode reaches it
	always_ff @(posedge clk) begin
		if (!nrst) begin
			idleCount <= RST_WORD;
		end else begin
			idleCount <= idleCount + 16'h0001;
		end
	end

	// A toggle of the tick bit happens when all lower bits roll over
	assign timerTick = &idleCount[IDLE_TICK_BIT-1:0];

	// ------------------------------------------------------------
	// Service interval monitor
	// ------------------------------------------------------------
	// Any write to the service offset restarts the count
	always_ff @(posedge clk) begin
		if (!nrst) begin
			svcCount <= 32'h0000_0000;
		end else if (!control[CTL_SVC_EN] || wiuWrHit(regWr, regAddr, OFS_SERVICE)) begin
			svcCount <= 32'h0000_0000;
		end else if (svcCount != 32'(SERVICE_LIMIT)) begin
			svcCount <= svcCount + 32'h0000_0001;
		end
	end

	assign runawayHit = control[CTL_SVC_EN] && (svcCount == 32'(SERVICE_LIMIT) - 32'h0000_0001);

	// ------------------------------------------------------------
	// Clock monitor
	// ------------------------------------------------------------
	// The monitored clock is a pin: synchronise, then time its rising edges
	always_ff @(posedge clk) begin
		if (!nrst) begin
			mclkSync <= 3'h0;
			mclkPrev <= 1'b0;
		end else begin
			mclkSync <= {mclkSync[1:0], monitoredClk};
			if (mclkSync[1] == mclkSync[2]) begin
				mclkPrev <= mclkSync[2];
			end
		end
	end

	// Gap counter saturates so a dead clock reports once
	always_ff @(posedge clk) begin
		if (!nrst) begin
			mclkGap <= 32'h0000_0000;
		end else if (!control[CTL_CLKMON_EN] || (mclkSync[1] && mclkSync[2] && !mclkPrev)) begin
			mclkGap <= 32'h0000_0000;
		end else if (mclkGap != 32'(CLKMON_LIMIT)) begin
			mclkGap <= mclkGap + 32'h0000_0001;
		end
	end

	assign clkLossHit = control[CTL_CLKMON_EN] && (mclkGap == 32'(CLKMON_LIMIT) - 32'h0000_0001);

	// ------------------------------------------------------------
	// Program fetch guard and illegal trap
	// ------------------------------------------------------------
	// Locations past the implemented program memory read as zero
	always_ff @(posedge clk) begin
		if (!nrst) begin
			fetchData <= RST_BYTE;
		end else if (fetchStrobe) begin
			fetchData <= (fetchAddr < 16'(ROM_WORDS)) ? romData : ILLEGAL_OPCODE;
		end
	end

	assign illegalHit = execStrobe && (execOpcode == ILLEGAL_OPCODE);

	// Trap holds until the core acknowledges its vector; a new hit wins
	always_ff @(posedge clk) begin
		if (!nrst) begin
			illegalTrap <= 1'b0;
		end else if (illegalHit) begin
			illegalTrap <= 1'b1;
		end else if (intAck && intReq && intVector[4:1] == SRC_ILLEGAL) begin
			illegalTrap <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Control registers
	// ------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!nrst) begin
			control <= RST_BYTE;
			vectorBase <= RST_BYTE;
			eventMask <= EV_W'(0);
			srcEnable <= NUM_MASKABLE'(0);
		end else begin
			if (wiuWrHit(regWr, regAddr, OFS_CONTROL)) begin
				control <= regWdata;
			end
			if (wiuWrHit(regWr, regAddr, OFS_VECTOR_BASE)) begin
				vectorBase <= regWdata;
			end
			if (wiuWrHit(regWr, regAddr, OFS_EVENT_MASK)) begin
				eventMask <= regWdata[EV_W-1:0];
			end
			if (wiuWrHit(regWr, regAddr, OFS_SRC_ENABLE_LO)) begin
				srcEnable[7:0] <= regWdata;
			end
			if (wiuWrHit(regWr, regAddr, OFS_SRC_ENABLE_HI)) begin
				srcEnable[NUM_MASKABLE-1:8] <= regWdata[NUM_MASKABLE-9:0];
			end
		end
	end

	// ------------------------------------------------------------
	// Event status, write one to clear, set wins
	// ------------------------------------------------------------
	logic [EV_W-1:0] evSet;
	assign evSet[EV_WAKE] = |(pinEdge & wakeEnableMask);
	assign evSet[EV_TIMER] = timerTick && control[CTL_TIMER_IE];
	assign evSet[EV_RUNAWAY] = runawayHit;
	assign evSet[EV_CLKLOSS] = clkLossHit;
	assign evSet[EV_ILLEGAL] = illegalHit;

	always_ff @(posedge clk) begin
		if (!nrst) begin
			eventStatus <= EV_W'(0);
		end else if (wiuWrHit(regWr, regAddr, OFS_EVENT_STATUS)) begin
			eventStatus <= (eventStatus & ~regWdata[EV_W-1:0]) | evSet;
		end else begin
			eventStatus <= eventStatus | evSet;
		end
	end

	// Level interrupt for unmasked status
	always_ff @(posedge clk) begin
		if (!nrst) begin
			irq <= 1'b0;
		end else begin
			irq <= |(eventStatus & eventMask);
		end
	end

	// ------------------------------------------------------------
	// Vectored priority, highest index wins
	// ------------------------------------------------------------
	always_comb begin
		srcReq = NUM_SRC'(0);
		srcReq[SRC_WAKE] = wakeAny;
		srcReq[SRC_TIMER] = eventStatus[EV_TIMER];
		srcReq[NUM_MASKABLE-1:2] = extIrq;
		srcReq[NUM_MASKABLE-1:0] = srcReq[NUM_MASKABLE-1:0] & srcEnable
			& {NUM_MASKABLE{control[CTL_GIE]}};
		srcReq[SRC_MONITOR] = eventStatus[EV_RUNAWAY] | eventStatus[EV_CLKLOSS];
		srcReq[SRC_ILLEGAL] = illegalTrap;
	end

	always_comb begin
		srcIdx = 4'h0;
		srcValid = 1'b0;
		for (int k = 0; k < NUM_SRC; k++) begin
			if (srcReq[k]) begin
				srcIdx = 4'(k);
				srcValid = 1'b1;
			end
		end
	end

	// Vector address: 32-byte table in the page chosen by software
	always_ff @(posedge clk) begin
		if (!nrst) begin
			intReq <= 1'b0;
			intVector <= RST_WORD;
		end else begin
			intReq <= srcValid;
			intVector <= {vectorBase, 3'b000, srcIdx, 1'b0};
		end
	end

	// ------------------------------------------------------------
	// Power states
	// ------------------------------------------------------------
	// Idle also ends on the timer tick, so the tick keeps time while idle
	always_comb begin
		next_power = power;
		case (power)
			WIU_RUN: begin
				if (wiuWrHit(regWr, regAddr, OFS_LOW_POWER) && regWdata[LP_STOP]) begin
					next_power = WIU_STOP;
				end else if (wiuWrHit(regWr, regAddr, OFS_LOW_POWER) && regWdata[LP_IDLE]) begin
					next_power = WIU_IDLE;
				end
			end
			WIU_STOP: begin
				if (evSet[EV_WAKE]) begin
					next_power = WIU_RUN;
				end
			end
			WIU_IDLE: begin
				if (evSet[EV_WAKE] || timerTick) begin
					next_power = WIU_RUN;
				end
			end
			default: next_power = WIU_RUN;
		endcase
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			power <= WIU_RUN;
			coreStopped <= 1'b0;
			coreIdle <= 1'b0;
			wakeEvent <= 1'b0;
		end else begin
			power <= next_power;
			coreStopped <= (next_power == WIU_STOP);
			coreIdle <= (next_power == WIU_IDLE);
			wakeEvent <= (power != WIU_RUN) && (next_power == WIU_RUN);
		end
	end

	// ------------------------------------------------------------
	// Read port, data one cycle after the strobe
	// ------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!nrst) begin
			regRdata <= RST_BYTE;
		end else if (regRd) begin
			if (regAddr == OFS_WAKE_EDGE_SELECT) begin
				regRdata <= wakeEdgeSelect;
			end else if (regAddr == OFS_WAKE_ENABLE_MASK) begin
				regRdata <= wakeEnableMask;
			end else if (regAddr == OFS_WAKE_PENDING_FLAGS) begin
				regRdata <= wakePendingFlags;
			end else if (regAddr == OFS_EVENT_STATUS) begin
				regRdata <= 8'(eventStatus);
			end else if (regAddr == OFS_EVENT_MASK) begin
				regRdata <= 8'(eventMask);
			end else if (regAddr == OFS_CONTROL) begin
				regRdata <= control;
			end else if (regAddr == OFS_VECTOR_BASE) begin
				regRdata <= vectorBase;
			end else if (regAddr == OFS_SRC_ENABLE_LO) begin
				regRdata <= srcEnable[7:0];
			end else if (regAddr == OFS_SRC_ENABLE_HI) begin
				regRdata <= 8'(srcEnable[NUM_MASKABLE-1:8]);
			end else begin
				regRdata <= RST_BYTE;
			end
		end else begin
			regRdata <= RST_BYTE;
		end
	end

endmodule
